// >>> core/ifd_pkg.sv
package ifd_pkg;
    // Word and field widths
    localparam int INSN_W      = 14;
    localparam int FADDR_W     = 7;
    localparam int BITSEL_W    = 3;
    localparam int LIT8_W      = 8;
    localparam int LIT11_W     = 11;
    localparam int DATA_W      = 8;
    // Field positions inside the instruction word
    localparam int GROUP_HI    = 13;
    localparam int GROUP_LO    = 12;
    localparam int DEST_POS    = 7;
    localparam int BIT_LO      = 7;
    localparam int SUBOP_HI    = 11;
    localparam int SUBOP_LO    = 8;
    localparam int LIT11_SEL   = 11;
    // Group codes held in the two top bits
    localparam logic [1:0] GRP_BYTE  = 2'h0;
    localparam logic [1:0] GRP_BIT   = 2'h1;
    localparam logic [1:0] GRP_JUMP  = 2'h2;
    localparam logic [1:0] GRP_LIT   = 2'h3;
    // Selected opcodes within the groups
    localparam logic [3:0] OP_MOVWF  = 4'h0;
    localparam logic [3:0] OP_CLR    = 4'h1;
    localparam logic [3:0] OP_DECFSZ = 4'hB;
    localparam logic [3:0] OP_INCFSZ = 4'hF;
    localparam logic [1:0] BOP_BTFSC = 2'h2;
    localparam logic [1:0] BOP_BTFSS = 2'h3;
    localparam logic [INSN_W-1:0] WORD_RETURN  = 14'h0008;
    localparam logic [INSN_W-1:0] WORD_RETFIE  = 14'h0009;
    localparam logic [5:0]        RETLW_HI     = 6'h34;
    // Instruction cycle: four oscillator periods
    localparam int Q_PHASES    = 4;
    localparam logic [1:0] Q_LAST = 2'h3;
    // Reset value of the held instruction: an all-zero word is no_operation
    localparam logic [INSN_W-1:0] NO_OPERATION = 14'h0000;

    // Instruction category
    typedef enum logic [1:0] {
        IFD_CAT_BYTE,
        IFD_CAT_BIT,
        IFD_CAT_LITCTL
    } ifd_cat_t;

    // Decoded operand fields
    typedef struct packed {
        ifd_cat_t             cat;
        logic [FADDR_W-1:0]   faddr;
        logic                 dest_file;
        logic [BITSEL_W-1:0]  bitsel;
        logic                 lit_wide;
        logic [LIT11_W-1:0]   literal;
        logic                 uses_file;
        logic                 is_skip;
        logic                 is_jump;
    } ifd_fields_t;

    // Write-back steering for the datapath
    typedef struct packed {
        logic                 rd_file;
        logic                 wr_file;
        logic                 wr_acc;
        logic [FADDR_W-1:0]   faddr;
        logic [DATA_W-1:0]    bit_mask;
    } ifd_route_t;
endpackage

// >>> core/ifd_field_split.sv
`timescale 1ns/1ps
// Pure combinational field extraction of one instruction word
module ifd_field_split
    import ifd_pkg::*;
(
    // Instruction in
    input  wire logic [ifd_pkg::INSN_W-1:0] insn,
    // Fields out
    output ifd_pkg::ifd_fields_t            fields
);
    import ifd_pkg::*;

    logic [1:0] group;    // Top two opcode bits
    logic [3:0] subop;    // Byte-group opcode nibble

    assign group = insn[GROUP_HI:GROUP_LO];
    assign subop = insn[SUBOP_HI:SUBOP_LO];

    // Classification and operand pick-off
    always_comb begin
        fields           = '0;
        fields.faddr     = insn[FADDR_W-1:0];
        fields.dest_file = insn[DEST_POS];
        fields.bitsel    = insn[BIT_LO+BITSEL_W-1:BIT_LO];
        case (group)
            GRP_BYTE: begin
                // Control words like return live here but name no file
                fields.cat       = IFD_CAT_BYTE;
                fields.uses_file = (subop != OP_MOVWF)
                                 || insn[DEST_POS];
                fields.is_skip   = (subop == OP_DECFSZ)
                                 || (subop == OP_INCFSZ);
                fields.is_jump   = (insn == WORD_RETURN)
                                 || (insn == WORD_RETFIE);
                if (subop == OP_CLR && !insn[DEST_POS]) begin
                    fields.uses_file = 1'b0;                  // Clear acc only
                end
            end
            GRP_BIT: begin
                fields.cat       = IFD_CAT_BIT;
                fields.uses_file = 1'b1;
                fields.is_skip   = insn[SUBOP_HI];            // Test forms
            end
            GRP_JUMP: begin
                fields.cat      = IFD_CAT_LITCTL;
                fields.lit_wide = 1'b1;
                fields.literal  = insn[LIT11_W-1:0];
                fields.is_jump  = 1'b1;
            end
            default: begin
                fields.cat     = IFD_CAT_LITCTL;
                fields.literal = {3'h0, insn[LIT8_W-1:0]};
                fields.is_jump = (insn[13:8] == RETLW_HI);
            end
        endcase
    end
endmodule

// >>> core/ifd_core.sv
`timescale 1ns/1ps
module ifd_core
    import ifd_pkg::*;
(
    // Clock and reset
    input  wire logic                          clock,
    input  wire logic                          rst_n,
    // Program memory side
    input  wire logic [ifd_pkg::INSN_W-1:0]    fetch_word,
    output logic                               fetch_strobe,
    // Datapath feedback: skip condition of the executing word is true
    input  wire logic                          skip_true,
    // Decoded instruction to the datapath
    output ifd_pkg::ifd_fields_t               exec_fields,
    output logic                               exec_valid,
    output logic                               no_operation,
    // Phase markers
    output logic [1:0]                         q_phase,
    output logic                               cycle_end,
    // Register file and accumulator steering
    output ifd_pkg::ifd_route_t                route
);
    import ifd_pkg::*;

    // Phase sequencer states, one per oscillator period
    typedef enum logic [1:0] {
        IFD_Q1,
        IFD_Q2,
        IFD_Q3,
        IFD_Q4
    } ifd_q_t;

    ifd_q_t               q_state;      // Current period in the cycle
    logic [INSN_W-1:0]    prefetch;     // Word fetched ahead
    logic [INSN_W-1:0]    exec_word;    // Word now executing
    logic                 flush;        // Next cycle must be idle
    ifd_fields_t          dec_fields;   // Fields of the executing word
    ifd_fields_t          next_fields;  // Gated copy for the output

    // One-hot mask for a bit position, used by set/clear and tests
    function automatic logic [DATA_W-1:0] bit_mask_of(
        input logic [BITSEL_W-1:0] sel
    );
        bit_mask_of = DATA_W'(1) << sel;
    endfunction

    ifd_field_split u_split (
        .insn   (exec_word),
        .fields (dec_fields)
    );

    // Four-period instruction cycle; Q4 closes each cycle
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            q_state <= IFD_Q1;
        end else begin
            case (q_state)
                IFD_Q1:  q_state <= IFD_Q2;
                IFD_Q2:  q_state <= IFD_Q3;
                IFD_Q3:  q_state <= IFD_Q4;
                IFD_Q4:  q_state <= IFD_Q1;
                default: q_state <= IFD_Q1;
            endcase
        end
    end

    // Phase outputs registered so the top drives from flops
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            q_phase   <= 2'h0;
            cycle_end <= 1'b0;
        end else begin
            q_phase   <= q_state;
            cycle_end <= (q_state == IFD_Q4);
        end
    end

    // Fetch strobe: word is latched from memory at the end of Q4
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            fetch_strobe <= 1'b0;
        end else begin
            fetch_strobe <= (q_state == IFD_Q3);
        end
    end

    // Pipeline: prefetch overlaps execution of the current word
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            prefetch  <= NO_OPERATION;
            exec_word <= NO_OPERATION;
        end else if (q_state == IFD_Q4) begin
            prefetch  <= fetch_word;
            // The word behind a jump is loaded but masked by flush, so
            // exactly one word is lost and the following one still runs
            exec_word <= prefetch;
        end
    end

    // Flush flag decided at Q4 from the word ending its cycle.
    // Skip is sampled late so the datapath has Q1-Q3 to resolve it.
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            flush <= 1'b1;   // Reset value held in exec_word is not run
        end else if (q_state == IFD_Q4) begin
            if (flush) begin
                flush <= 1'b0;  // Idle cycle itself never flushes
            end else begin
                flush <= dec_fields.is_jump
                       || (dec_fields.is_skip && skip_true);
            end
        end
    end

    // Idle cycles present all-zero fields to the datapath
    always_comb begin
        next_fields = dec_fields;
        if (flush) begin
            next_fields = '0;
        end
    end

    // Decoded fields and valid, registered
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            exec_fields  <= '0;
            exec_valid   <= 1'b0;
            no_operation <= 1'b1;
        end else begin
            exec_fields  <= next_fields;
            exec_valid   <= !flush;
            no_operation <= flush;
        end
    end

    // Register file steering: read in Q2, write in Q4.
    // Read happens even for write-only words so side effects match.
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            route <= '0;
        end else begin
            route.faddr    <= dec_fields.faddr;
            route.bit_mask <= bit_mask_of(dec_fields.bitsel);
            route.rd_file  <= !flush && dec_fields.uses_file
                            && (q_state == IFD_Q1);
            route.wr_file  <= !flush && dec_fields.uses_file
                            && (q_state == IFD_Q3)
                            && ((dec_fields.cat == IFD_CAT_BIT
                                 && !dec_fields.is_skip)
                                || (dec_fields.cat == IFD_CAT_BYTE
                                    && dec_fields.dest_file
                                    && !dec_fields.is_jump));
            route.wr_acc   <= !flush && (q_state == IFD_Q3)
                            && ((dec_fields.cat == IFD_CAT_BYTE
                                 && !dec_fields.dest_file
                                 && !dec_fields.is_jump)
                                || (dec_fields.cat == IFD_CAT_LITCTL
                                    && !dec_fields.lit_wide));
        end
    end
endmodule

// >>> tb/ifd_core_props.sv
`timescale 1ns/1ps
// Timing and steering relations of the decoder, seen at its ports
module ifd_core_props
    import ifd_pkg::*;
(
    // Clock and reset
    input wire logic                clock,
    input wire logic                rst_n,
    // Watched outputs and feedback
    input wire logic                fetch_strobe,
    input wire logic                skip_true,
    input wire logic                exec_valid,
    input wire logic                no_operation,
    input wire logic                cycle_end,
    input ifd_pkg::ifd_fields_t     exec_fields,
    input ifd_pkg::ifd_route_t      route
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    // Both strobes repeat every four clocks, never in between
    a_end_period: assert property (
        cycle_end |=> !cycle_end[*3] ##1 cycle_end)
        else $error("cycle end period is not four clocks");
    a_fetch_period: assert property (
        fetch_strobe |=> !fetch_strobe[*3] ##1 fetch_strobe)
        else $error("fetch strobe period is not four clocks");
    // A store must follow its own read two clocks earlier
    a_write_after_read: assert property (
        route.wr_file |-> $past(route.rd_file, 2))
        else $error("file store without a prior read");
    a_read_addr: assert property (
        route.rd_file |-> exec_fields.uses_file
            && route.faddr == exec_fields.faddr)
        else $error("file read address mismatch");
    a_acc_only: assert property (
        exec_valid && exec_fields.cat == IFD_CAT_BYTE && route.wr_acc
            |-> !route.wr_file && !exec_fields.dest_file)
        else $error("accumulator result also stored to file");
    a_file_dest: assert property (
        route.wr_file && exec_fields.cat == IFD_CAT_BYTE
            |-> exec_fields.dest_file)
        else $error("file store with destination zero");
    a_bit_mask: assert property (
        route.rd_file && exec_fields.cat == IFD_CAT_BIT
            |-> route.bit_mask == (8'h01 << exec_fields.bitsel))
        else $error("bit mask is not one-hot of bit field");
    // Jumps are followed by one idle cycle, which starts within four clocks
    a_jump_flush: assert property (
        exec_valid && exec_fields.is_jump |-> ##[1:4] no_operation)
        else $error("jump not followed by idle cycle");
    a_idle_clean: assert property (
        no_operation |-> !exec_valid && exec_fields == '0)
        else $error("idle cycle carries a live word");
    c_store: cover property (route.wr_file);
    c_skip: cover property (exec_valid && exec_fields.is_skip && skip_true);
    c_flush: cover property (no_operation && $past(exec_valid));
endmodule

// >>> tb/instruction_format_decode_tb_top.sv
`timescale 1ns/1ps
module instruction_format_decode_tb_top;
    import ifd_pkg::*;
    logic              clock = 1'b0;
    logic              rst_n = 1'b0;
    logic [INSN_W-1:0] fetch_word = 14'h0000;
    logic              skip_true = 1'b0;
    logic              fetch_strobe, exec_valid, no_operation, cycle_end;
    logic [1:0]        q_phase;
    ifd_fields_t       exec_fields;
    ifd_route_t        route;
    int                fail_count = 0;
    int                comparisons = 0;
    logic [INSN_W-1:0] prog [$];
    always #50 clock = ~clock;
    ifd_core dut_u (.clock(clock), .rst_n(rst_n), .fetch_word(fetch_word),
        .fetch_strobe(fetch_strobe), .skip_true(skip_true),
        .exec_fields(exec_fields), .exec_valid(exec_valid),
        .no_operation(no_operation), .q_phase(q_phase),
        .cycle_end(cycle_end), .route(route));
    // Feed the next word once the strobe period's edge has taken one
    always @(posedge clock) begin
        if (rst_n && fetch_strobe === 1'b1) begin
            fetch_word <= (prog.size() > 0) ? prog.pop_front() : 14'h0700;
        end
    end
    task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // Sample mid-way through each fetch strobe period
    task automatic wait_strobe();
        int n;
        n = 0;
        do begin
            @(negedge clock);
            n++;
        end while (fetch_strobe !== 1'b1 && n < 8);
        check("strobe", fetch_strobe, 1'b1);
        // Phase output lags the sequencer by one clock
        check("phase", q_phase, Q_LAST - 2'h1);
    endtask
    task automatic expect_word(logic [INSN_W-1:0] w);
        logic ret;
        // Return words sit in the byte group but load nothing
        ret = (w == WORD_RETURN) || (w == WORD_RETFIE);
        check("valid", exec_valid, 1'b1);
        case (w[13:12])
            2'h0: begin
                check("cat", exec_fields.cat, IFD_CAT_BYTE);
                check("faddr", route.faddr, w[6:0]);
                check("wr_acc", route.wr_acc, !w[7] && !ret);
                check("wr_file", route.wr_file, w[7]);
            end
            2'h1: begin
                check("cat", exec_fields.cat, IFD_CAT_BIT);
                check("faddr", route.faddr, w[6:0]);
                check("mask", route.bit_mask, 8'h01 << w[9:7]);
                check("wr_file", route.wr_file, !w[11]);
            end
            default: begin
                check("cat", exec_fields.cat, IFD_CAT_LITCTL);
                check("wide", exec_fields.lit_wide, !w[12]);
                if (w[12]) check("lit", exec_fields.literal, w[7:0]);
                else check("lit", exec_fields.literal, w[10:0]);
                check("wr_acc", route.wr_acc, w[12]);
            end
        endcase
    endtask
    // Words after which the next fetched word must be dropped
    function automatic logic flushes(logic [INSN_W-1:0] v, logic skp);
        logic tst;
        tst = (v[GROUP_HI:GROUP_LO] == GRP_BYTE
               && (v[SUBOP_HI:SUBOP_LO] == OP_DECFSZ
                   || v[SUBOP_HI:SUBOP_LO] == OP_INCFSZ))
            || (v[GROUP_HI:GROUP_LO] == GRP_BIT && v[SUBOP_HI]);
        flushes = v[GROUP_HI:GROUP_LO] == GRP_JUMP
            || v[13:8] == RETLW_HI
            || v == WORD_RETURN || v == WORD_RETFIE
            || (skp && tst);
    endfunction
    // Reset, stream the program, and judge each instruction cycle
    task automatic run(input logic skp);
        logic [INSN_W-1:0] w [$];
        logic drop;
        w = prog;
        rst_n <= 1'b0;
        skip_true <= skp;
        fetch_word <= prog.pop_front();
        repeat (4) @(posedge clock);
        rst_n <= 1'b1;
        wait_strobe();
        check("reset idle", no_operation, 1'b1);
        // Prefetched word resets to no_operation and runs before the first fetched word
        wait_strobe();
        expect_word(NO_OPERATION);
        drop = 1'b0;
        foreach (w[i]) begin
            wait_strobe();
            if (drop) begin
                check("idle", no_operation, 1'b1);
                check("dropped", exec_valid, 1'b0);
            end else begin
                expect_word(w[i]);
            end
            drop = !drop && flushes(w[i], skp);
        end
        // Step past the strobe so the feeder cannot race the next reset
        repeat (2) @(posedge clock);
    endtask
    task automatic t_byte();
        prog = '{14'h0700, 14'h07FF, 14'h00A0, 14'h0B7F, 14'h0008,
            14'h07FF, 14'h0100};
        run(1'b0);
    endtask
    task automatic t_bit();
        prog = '{14'h1005, 14'h17FF, 14'h1990, 14'h1E81};
        run(1'b0);
    endtask
    // Back-to-back jumps: the second is dropped and triggers nothing
    task automatic t_lit();
        prog = '{14'h30A5, 14'h395A, 14'h2FFF, 14'h2000, 14'h2000,
            14'h3001, 14'h3455, 14'h3E3C, 14'h3002};
        run(1'b0);
    endtask
    task automatic t_skip();
        prog = '{14'h0B90, 14'h0700, 14'h0F05, 14'h07FF, 14'h1E81,
            14'h1005, 14'h1990, 14'h30A5, 14'h3011};
        run(1'b1);
    endtask
    task automatic end_of_test();
        $display("Comparisons %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    initial begin
        t_byte();
        t_bit();
        t_lit();
        t_skip();
        end_of_test();
    end
    // Whole run needs under two hundred clocks
    initial begin
        #200000;
        fail_count++;
        end_of_test();
    end
endmodule
bind ifd_core ifd_core_props chk_u (.clock(clock), .rst_n(rst_n),
    .fetch_strobe(fetch_strobe), .skip_true(skip_true),
    .exec_valid(exec_valid), .no_operation(no_operation),
    .cycle_end(cycle_end), .exec_fields(exec_fields), .route(route));
